// ===== tpd_port.sv
// test-point strap capture and debug output port
module tpd_port
  import tpd_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [TP_W-1:0]  test_point_port_i,
  output logic      [TP_W-1:0]  test_point_port_o,
  output logic      [TP_W-1:0]  test_point_port_oe_o,
  input  wire logic [TDO_W-1:0] jtag_tdo_strap_i,
  output logic      [TDO_W-1:0] jtag_tdo_strap_o,
  output logic      [TDO_W-1:0] jtag_tdo_strap_oe_o,
  output logic      [TDO_W-1:0] jtag_tdo_strap_pu_o,
  input  wire logic [TDO_W-1:0] jtag_tdo_data_i,
  input  wire logic             sw_sel_we_i,
  input  wire logic [TDO_W-1:0] sw_sel_i,
  output logic      [TP_W-1:0]  strap_config_o,
  output logic      [TDO_W-1:0] tdo_strap_o,
  output logic                  strap_done_o
);
  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  tpd_state_t       state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [TP_W-1:0]  cfg, next_cfg;
  logic [TDO_W-1:0] sel, next_sel;
  logic [TDO_W-1:0] tdo_cap, next_tdo_cap;
  logic [3:0]       div, next_div;
  logic [TP_W-1:0]  tp_out, next_tp_out;
  logic [TP_W-1:0]  tp_oe, next_tp_oe;
  logic [TP_W-1:0]  clk_bits;
  logic             done;

  // debug clocks are ratios of this clock; a true 60 MHz needs a faster source
  always_comb begin
    clk_bits = TP_ZERO;
    clk_bits[0] = div[0];
    // each divider bit halves the rate: 60, 30, 15, 7.5 in the debug set
    clk_bits[1] = div[1];
    clk_bits[2] = div[3];
    clk_bits[4] = div[2];
    clk_bits[5] = div[0];
  end

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_cfg     = cfg;
    next_sel     = sel;
    next_tdo_cap = tdo_cap;
    next_div     = div + 4'h1;
    case (state)
      TPD_RESET: begin
        next_state = TPD_WAIT;
        next_cnt   = '0;
      end
      TPD_WAIT: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(SAMPLE_CYCLES - 1)) begin
          next_cfg     = test_point_port_i;
          next_tdo_cap = jtag_tdo_strap_i;
          next_sel     = jtag_tdo_strap_i;
          next_state   = TPD_RUN;
        end
      end
      TPD_RUN: begin
        if (sw_sel_we_i) begin
          next_sel = sw_sel_i;
        end
      end
      default: begin
        next_state = TPD_RESET;
      end
    endcase
    next_tp_out = TP_ZERO;
    next_tp_oe  = TP_ZERO;
    if (next_state == TPD_RUN && next_sel[1:0] == SEL_LOW && !next_sel[2]) begin
      next_tp_out = clk_bits;
      next_tp_oe  = ~TP_ZERO;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state   <= TPD_RESET;
      cnt     <= '0;
      cfg     <= TP_ZERO;
      sel     <= SEL_HIZ;
      tdo_cap <= TDO_PULL;
      div     <= '0;
      tp_out  <= TP_ZERO;
      tp_oe   <= TP_ZERO;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      cfg     <= next_cfg;
      sel     <= next_sel;
      tdo_cap <= next_tdo_cap;
      div     <= next_div;
      tp_out  <= next_tp_out;
      tp_oe   <= next_tp_oe;
    end
  end

  // ----------------------------------------------------------------
  // pins; tdo outputs return only once the strap is captured
  // ----------------------------------------------------------------
  logic [TDO_W-1:0] tdo_out;
  logic [TDO_W-1:0] tdo_oe;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdo_out <= '0;
      tdo_oe  <= '0;
    end else begin
      tdo_out <= jtag_tdo_data_i;
      tdo_oe  <= {TDO_W{next_state == TPD_RUN}};
    end
  end

  // done is its own flop so the status output is registered
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done <= 1'b0;
    end else begin
      done <= (next_state == TPD_RUN);
    end
  end

  assign test_point_port_o    = tp_out;
  assign test_point_port_oe_o = tp_oe;
  assign jtag_tdo_strap_o     = tdo_out;
  assign jtag_tdo_strap_oe_o  = tdo_oe;
  assign strap_config_o       = cfg;
  assign tdo_strap_o          = tdo_cap;
  assign strap_done_o         = done;

  // pull-up enable is a flop held high so an open board reads x111
  logic [TDO_W-1:0] pu;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pu <= TDO_PULL;
    end else begin
      pu <= TDO_PULL;
    end
  end
  assign jtag_tdo_strap_pu_o = pu;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_tp_hiz_wait: assert property (!done |-> tp_oe == TP_ZERO)
    else $error("test points driven before capture");
  a_capture_time: assert property ($rose(state == TPD_WAIT) |-> ##15 done)
    else $error("capture not at 1.5 us");
  a_cfg_latch: assert property ($rose(done) |-> cfg == $past(test_point_port_i))
    else $error("strap config not latched");
  a_tdo_latch: assert property ($rose(done) |-> tdo_cap == $past(jtag_tdo_strap_i))
    else $error("tdo strap not latched");
  a_tdo_oe_off: assert property (!done |-> tdo_oe == '0)
    else $error("tdo driven before capture");
  a_hiz_default: assert property (done && sel == SEL_HIZ |-> tp_oe == TP_ZERO)
    else $error("default select drives pins");
  a_clk_debug: assert property (done && sel == SEL_CLK |-> tp_oe == ~TP_ZERO)
    else $error("clock debug not driven");
  a_low_bits: assert property (tp_out[3] == 1'b0 && tp_out[7:6] == 2'h0)
    else $error("low debug bits toggling");
  a_sw_select: assert property (done && sw_sel_we_i |=> sel == $past(sw_sel_i))
    else $error("software select ignored");
  a_pullup_on: assert property (pu == TDO_PULL)
    else $error("pull-ups off");

  c_hiz_run:   cover property ($rose(done) ##1 sel == SEL_HIZ);
  c_clk_run:   cover property ($rose(done) ##1 sel == SEL_CLK);
  c_sw_change: cover property (done && sw_sel_we_i && sw_sel_i != sel);
  c_refused:   cover property (!done && sw_sel_we_i);

  // ----------------------------------------------------------------
  // sequencing and latch checks
  // ----------------------------------------------------------------
  // a write before capture must not reach the selection
  a_sel_refused: assert property (!done && next_state != TPD_RUN && sw_sel_we_i
                                  |=> sel == $past(sel))
    else $error("early select write taken");

  a_done_hold: assert property (done |=> done)
    else $error("done dropped without reset");

  a_cfg_stable: assert property (done |=> $stable(cfg))
    else $error("strap config changed after capture");

  a_tdo_stable: assert property (done |=> $stable(tdo_cap))
    else $error("tdo strap changed after capture");

  a_tdo_oe_on: assert property (done |-> tdo_oe == '1)
    else $error("tdo not driven after capture");

  a_wait_count: assert property (state == TPD_WAIT |-> cnt < CNT_W'(SAMPLE_CYCLES))
    else $error("wait counter overran");

  // ----------------------------------------------------------------
  // output function checks
  // ----------------------------------------------------------------
  // enables move as one group; a partial set would be a decode fault
  a_oe_group: assert property (tp_oe == TP_ZERO || tp_oe == ~TP_ZERO)
    else $error("partial test-point enable");

  a_hiz_quiet: assert property (done && sel != SEL_CLK |-> tp_out == TP_ZERO)
    else $error("idle test points switching");

  a_fast_toggle: assert property (done && sel == SEL_CLK && $past(done && sel == SEL_CLK)
                                  |-> tp_out[0] != $past(tp_out[0]))
    else $error("fastest debug clock stuck");

  a_fast_pair: assert property (tp_out[5] == tp_out[0])
    else $error("paired fast debug clocks differ");
endmodule

// ===== tpd_pkg.sv
// package of constants for the test-point strap and debug port
package tpd_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned SAMPLE_DELAY_NS = 1500;
  // longest time, rounded down, at least one cycle
  localparam int unsigned SAMPLE_CYCLES_RAW = SAMPLE_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_CYCLES =
    (SAMPLE_CYCLES_RAW < 1) ? 1 : SAMPLE_CYCLES_RAW;
  localparam int unsigned CNT_W = 5;

  // ----------------------------------------------------------------
  // widths and selection codes
  // ----------------------------------------------------------------
  localparam int unsigned TP_W   = 8;
  localparam int unsigned TDO_W  = 3;
  localparam logic [2:0]  SEL_HIZ   = 3'h7;
  localparam logic [2:0]  SEL_CLK   = 3'h2;
  localparam logic [1:0]  SEL_LOW   = 2'h2; // low two bits of the match
  localparam logic [2:0]  TDO_PULL  = 3'h7;
  localparam logic [7:0]  TP_ZERO   = 8'h00;
  // clock debug: sources of each bit, 0=low 1=60M 2=30M 3=15M 4=7.5M
  localparam logic [2:0]  SRC_LOW = 3'h0;
  localparam logic [2:0]  SRC_60  = 3'h1;
  localparam logic [2:0]  SRC_30  = 3'h2;
  localparam logic [2:0]  SRC_15  = 3'h3;
  localparam logic [2:0]  SRC_7P5 = 3'h4;

  typedef enum logic [1:0] {
    TPD_RESET  = 2'b00,
    TPD_WAIT   = 2'b01,
    TPD_RUN    = 2'b10
  } tpd_state_t;
endpackage

// ===== tpd_board.sv
// board model: strap resistors and probe on the debug pins
module tpd_board (
  input  wire logic       clk_i,
  input  wire logic       strap_en_i,
  input  wire logic       tdo_open_i,
  input  wire logic [7:0] tp_strap_i,
  input  wire logic [2:0] tdo_strap_i,
  input  wire logic [7:0] tp_out_i,
  input  wire logic [7:0] tp_oe_i,
  input  wire logic [2:0] tdo_out_i,
  input  wire logic [2:0] tdo_oe_i,
  input  wire logic [2:0] tdo_pu_i,
  output logic      [7:0] tp_pin_o,
  output logic      [2:0] tdo_pin_o
);
  logic [7:0] float_q = 8'h5a;
  logic [2:0] tdo_bd;
  // released pins wander, so a stale level never passes for a capture
  always_ff @(posedge clk_i) float_q <= ~tp_pin_o;
  always_comb begin
    tdo_bd = (strap_en_i && !tdo_open_i) ? tdo_strap_i : tdo_pu_i;
    tp_pin_o = (tp_oe_i & tp_out_i) | (~tp_oe_i & (strap_en_i ? tp_strap_i : float_q));
    tdo_pin_o = (tdo_oe_i & tdo_out_i) | (~tdo_oe_i & tdo_bd);
  end
endmodule

// ===== tb_top.sv
// self-checking bench for the test-point strap and debug port
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tpd_pkg::*;
  logic clk_i = 0, rst_n_i = 0, strap_en = 1, tdo_open = 0, sw_sel_we_i = 0;
  logic [7:0] tps = 0, tp_pin, tp_o, tp_oe, cfg;
  logic [2:0] tds = 0, tdo_pin, tdo_o, tdo_oe, tdo_pu, tdo_cap, tdo_data = 0, tdo_d = 0;
  logic [2:0] sw_sel_i = 0;
  logic done;
  int num_errors = 0, checks_done = 0;
  int exp_tg [8] = '{32, 16, 4, 0, 8, 32, 0, 0};
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) tdo_data <= 3'($urandom);
  always @(posedge clk_i) tdo_d <= tdo_data;
  tpd_board u_tpd_board (.clk_i(clk_i), .strap_en_i(strap_en), .tdo_open_i(tdo_open),
    .tp_strap_i(tps), .tdo_strap_i(tds), .tp_out_i(tp_o), .tp_oe_i(tp_oe), .tdo_out_i(tdo_o),
    .tdo_oe_i(tdo_oe), .tdo_pu_i(tdo_pu), .tp_pin_o(tp_pin), .tdo_pin_o(tdo_pin));
  tpd_port u_tpd_port (.clk_i(clk_i), .rst_n_i(rst_n_i), .test_point_port_i(tp_pin),
    .test_point_port_o(tp_o), .test_point_port_oe_o(tp_oe), .jtag_tdo_strap_i(tdo_pin),
    .jtag_tdo_strap_o(tdo_o), .jtag_tdo_strap_oe_o(tdo_oe), .jtag_tdo_strap_pu_o(tdo_pu),
    .jtag_tdo_data_i(tdo_data), .sw_sel_we_i(sw_sel_we_i), .sw_sel_i(sw_sel_i),
    .strap_config_o(cfg), .tdo_strap_o(tdo_cap), .strap_done_o(done));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic run_case(logic [7:0] tp_s, logic [2:0] td_s, logic open);
    logic [2:0] sel;
    logic [7:0] prev;
    int n;
    int tg [8];
    sel = open ? 3'h7 : td_s;
    @(posedge clk_i);
    rst_n_i <= 0;
    strap_en <= 1;
    tps <= tp_s;
    tds <= td_s;
    tdo_open <= open;
    sw_sel_we_i <= 1;
    sw_sel_i <= ~sel;
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    check("oe_rst", {tp_oe, tdo_oe}, 0);
    @(posedge clk_i);
    rst_n_i <= 1;
    sw_sel_we_i <= 0;
    for (n = 1; n <= 40; n++) begin
      @(negedge clk_i);
      if (done === 1'b1) break;
      check("oe_wait", {tp_oe, tdo_oe}, 0);
    end
    if (n > 40) begin
      num_errors++;
      finish_test();
    end
    check("capture_time", n, 17);
    check("cfg", cfg, tp_s);
    check("tdo_cap", tdo_cap, sel);
    check("tdo_oe", {tdo_oe, tdo_pu}, 6'h3f);
    check("tp_oe", tp_oe, (sel == SEL_CLK) ? 8'hff : 8'h00);
    @(posedge clk_i) strap_en <= 0;
    tg = '{default: 0};
    @(negedge clk_i);
    prev = tp_pin;
    repeat (32) begin
      @(negedge clk_i);
      for (int b = 0; b < 8; b++) tg[b] += int'(tp_pin[b] != prev[b]);
      prev = tp_pin;
      check("tdo_out", tdo_pin, tdo_d);
      if (sel != SEL_CLK) check("hiz", tp_oe, 8'h00);
    end
    if (sel == SEL_CLK) begin
      for (int b = 0; b < 8; b++) check("toggles", tg[b], exp_tg[b]);
    end
    @(posedge clk_i);
    sw_sel_we_i <= 1;
    sw_sel_i <= (sel == SEL_CLK) ? SEL_HIZ : SEL_CLK;
    @(posedge clk_i) sw_sel_we_i <= 0;
    repeat (2) @(negedge clk_i);
    check("sw_sel", tp_oe, (sel == SEL_CLK) ? 8'h00 : 8'hff);
  endtask
  initial begin
    void'($urandom(91383));
    repeat (16) @(posedge clk_i);
    run_case(8'ha5, 3'h2, 1'b0);
    run_case(8'h00, 3'h2, 1'b1);
    run_case(8'hff, 3'h7, 1'b0);
    repeat (8) run_case(8'($urandom), 3'($urandom), 1'($urandom));
    finish_test();
  end
endmodule
